// ==== src/cchk_host.sv ====
module cchk_host import cchk_pkg::*; #(
    parameter int REPLY_WAIT = REPLY_WAIT_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cmdStart,
    input wire logic cmdFlash,
    input wire logic loaderReady,
    input wire logic [7:0] authKind,
    input wire logic [15:0] certSize,
    input wire logic [7:0] freqSel,
    input wire logic [7:0] supplySel,
    input wire logic [31:0] driverLen,
    output logic busy,
    output logic cmdRefused,
    output logic cmdDone,
    output logic replyOk,
    output logic linkErr,
    output logic [7:0] replyCode,
    output logic [7:0] statusCode,
    output logic [31:0] statusDetail,
    output logic [31:0] failLocation,
    output logic flashConfigured,
    output logic [7:0] txData,
    output logic txValid,
    input wire logic txReady,
    input wire logic [7:0] rxData,
    input wire logic rxValid
);

    localparam int WAIT_W = $clog2(REPLY_WAIT + 1);
    localparam logic [WAIT_W-1:0] WAIT_LAST = WAIT_W'(REPLY_WAIT - 1);

    typedef enum {ST_IDLE, ST_SEND, ST_WAIT} cchk_state_t;

    cchk_rsp_if rsp ();

    cchk_state_t state_q, state_d;
    cchk_frame_t frame_q, frame_d;
    logic [3:0] frameLen_q, frameLen_d;
    logic [3:0] idx_q, idx_d;
    logic flash_q, flash_d;
    logic [WAIT_W-1:0] wait_q, wait_d;
    logic refused_q, refused_d;
    logic done_q, done_d;
    logic ok_q, ok_d;
    logic linkErr_q, linkErr_d;
    logic [7:0] res_q, res_d;
    logic [7:0] sts_q, sts_d;
    logic [31:0] detail_q, detail_d;
    logic [31:0] loc_q, loc_d;
    logic flashCfg_q, flashCfg_d;

    logic [7:0] certSum;
    logic [7:0] flashSum;
    logic certBad;
    logic flashBad;
    logic [7:0] rspRes;
    logic [7:0] okRes;
    logic [7:0] errRes;
    logic [7:0] okLen;

    // ------------------------------------------------------------
    // Request framing
    // ------------------------------------------------------------
    // negate the byte sum from length high up
    assign certSum = 8'h00 - (LEN_HIGH_BYTE + LEN_CERT_CMD + CMD_CERT_CHECK
        + authKind + RSV_FILL[15:8] + RSV_FILL[7:0]
        + certSize[15:8] + certSize[7:0]);
    assign flashSum = 8'h00 - (LEN_HIGH_BYTE + LEN_FLASH_CMD + CMD_FLASH_SET
        + freqSel + supplySel + driverLen[31:24] + driverLen[23:16]
        + driverLen[15:8] + driverLen[7:0]);

    // only the plain CRC check is sent
    // oversize certificate stopped before the link
    // no check until the loader is in place
    assign certBad = (authKind != AUTH_PLAIN_CRC)
        || (certSize > CERT_SIZE_MAX) || !loaderReady;
    assign flashBad = (freqSel > FREQ_SEL_MAX)
        || (supplySel > SUPPLY_SEL_MAX) || (driverLen == DRV_LEN_ZERO)
        || (driverLen > DRV_LEN_MAX);

    // ------------------------------------------------------------
    // Reply decoding
    // ------------------------------------------------------------
    assign rspRes = rsp.body[POS_RES];
    assign okRes = flash_q ? CMD_FLASH_SET : CMD_CERT_CHECK;
    assign errRes = flash_q ? RES_FLASH_ERR : RES_CERT_ERR;
    assign okLen = flash_q ? LEN_STATUS : LEN_CERT_OK;

    always_comb begin
        state_d = state_q;
        frame_d = frame_q;
        frameLen_d = frameLen_q;
        idx_d = idx_q;
        flash_d = flash_q;
        wait_d = wait_q;
        refused_d = 1'b0;
        done_d = 1'b0;
        ok_d = ok_q;
        linkErr_d = linkErr_q;
        res_d = res_q;
        sts_d = sts_q;
        detail_d = detail_q;
        loc_d = loc_q;
        flashCfg_d = flashCfg_q;
        case (state_q)
            ST_IDLE: begin
                if (cmdStart && (cmdFlash ? flashBad : certBad)) begin
                    refused_d = 1'b1;
                end else if (cmdStart) begin
                    flash_d = cmdFlash;
                    idx_d = 4'h0;
                    state_d = ST_SEND;
                    if (cmdFlash) begin
                        // flash setting frame, first byte lowest
                        frame_d = {END_BYTE, flashSum, driverLen[7:0],
                            driverLen[15:8], driverLen[23:16],
                            driverLen[31:24], supplySel, freqSel,
                            CMD_FLASH_SET, LEN_FLASH_CMD, LEN_HIGH_BYTE,
                            HDR_START_BYTE};
                        frameLen_d = FLASH_FRAME_LEN;
                    end else begin
                        frame_d = {8'h00, END_BYTE, certSum, certSize[7:0],
                            certSize[15:8], RSV_FILL[7:0], RSV_FILL[15:8],
                            authKind, CMD_CERT_CHECK, LEN_CERT_CMD,
                            LEN_HIGH_BYTE, HDR_START_BYTE};
                        frameLen_d = CERT_FRAME_LEN;
                    end
                end
            end
            ST_SEND: begin
                if (txReady) begin
                    idx_d = idx_q + 4'h1;
                    if (idx_q == frameLen_q - 4'h1) begin
                        // Park on byte 0 so txData never indexes off the frame
                        idx_d = 4'h0;
                        wait_d = '0;
                        state_d = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                wait_d = wait_q + {{(WAIT_W-1){1'b0}}, 1'b1};
                if (rsp.valid) begin
                    done_d = 1'b1;
                    state_d = ST_IDLE;
                    res_d = rspRes;
                    ok_d = 1'b0;
                    linkErr_d = 1'b0;
                    sts_d = 8'h00;
                    detail_d = '1;
                    loc_d = '1;
                    // cert success reply carries only reserved bytes; flash success reply carries a status byte
                    if (rsp.good && rspRes == okRes && rsp.len == okLen) begin
                        ok_d = 1'b1;
                        if (flash_q) begin
                            sts_d = rsp.body[POS_STS];
                        end
                    // error reply with status fields, MSB first
                    // one status per reply is all there is
                    end else if (rsp.good && rspRes == errRes
                        && rsp.len == LEN_STATUS) begin
                        sts_d = rsp.body[POS_STS];
                        detail_d = {rsp.body[POS_DETAIL],
                            rsp.body[POS_DETAIL+1], rsp.body[POS_DETAIL+2],
                            rsp.body[POS_DETAIL+3]};
                        loc_d = {rsp.body[POS_LOC], rsp.body[POS_LOC+1],
                            rsp.body[POS_LOC+2], rsp.body[POS_LOC+3]};
                    end else begin
                        linkErr_d = 1'b1;
                    end
                    // gate for later external flash commands
                    if (flash_q) begin
                        flashCfg_d = rsp.good && rspRes == okRes
                            && rsp.len == okLen;
                    end
                end else if (wait_q == WAIT_LAST) begin
                    // Silent device: give up rather than hang the host
                    done_d = 1'b1;
                    ok_d = 1'b0;
                    linkErr_d = 1'b1;
                    state_d = ST_IDLE;
                    // unanswered flash setting leaves flash unset
                    if (flash_q) begin
                        flashCfg_d = 1'b0;
                    end
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            frame_q <= '0;
            frameLen_q <= 4'h0;
            idx_q <= 4'h0;
            flash_q <= 1'b0;
            wait_q <= '0;
            refused_q <= 1'b0;
            done_q <= 1'b0;
            ok_q <= 1'b0;
            linkErr_q <= 1'b0;
            res_q <= 8'h00;
            sts_q <= 8'h00;
            detail_q <= '0;
            loc_q <= '0;
            flashCfg_q <= 1'b0;
        end else begin
            state_q <= state_d;
            frame_q <= frame_d;
            frameLen_q <= frameLen_d;
            idx_q <= idx_d;
            flash_q <= flash_d;
            wait_q <= wait_d;
            refused_q <= refused_d;
            done_q <= done_d;
            ok_q <= ok_d;
            linkErr_q <= linkErr_d;
            res_q <= res_d;
            sts_q <= sts_d;
            detail_q <= detail_d;
            loc_q <= loc_d;
            flashCfg_q <= flashCfg_d;
        end
    end

    // ------------------------------------------------------------
    // Reply receiver
    // ------------------------------------------------------------
    // receiver hunts for the reply start byte
    cchk_reply_rx u_rx (
        .clk(clk),
        .sys_rst(sys_rst),
        .rxData(rxData),
        .rxValid(rxValid),
        .rsp(rsp)
    );

    assign busy = (state_q != ST_IDLE);
    assign txValid = (state_q == ST_SEND);
    assign txData = frame_q[idx_q];
    assign cmdRefused = refused_q;
    assign cmdDone = done_q;
    assign replyOk = ok_q;
    assign linkErr = linkErr_q;
    assign replyCode = res_q;
    assign statusCode = sts_q;
    assign statusDetail = detail_q;
    assign failLocation = loc_q;
    assign flashConfigured = flashCfg_q;

endmodule // cchk_host

// ==== src/cchk_pkg.sv ====
package cchk_pkg;

    // ------------------------------------------------------------
    // Framing bytes and codes
    // ------------------------------------------------------------
    localparam logic [7:0] HDR_START_BYTE = 8'h01;
    localparam logic [7:0] END_BYTE = 8'h03;
    localparam logic [7:0] DATA_START_BYTE = 8'h81;
    localparam logic [7:0] LEN_HIGH_BYTE = 8'h00;
    localparam logic [7:0] CMD_CERT_CHECK = 8'h27;
    localparam logic [7:0] CMD_FLASH_SET = 8'h36;
    localparam logic [7:0] RES_CERT_ERR = 8'hA7;
    localparam logic [7:0] RES_FLASH_ERR = 8'hB6;
    localparam logic [7:0] LEN_CERT_CMD = 8'h06;
    localparam logic [7:0] LEN_FLASH_CMD = 8'h07;
    localparam logic [7:0] LEN_CERT_OK = 8'h05;
    localparam logic [7:0] LEN_STATUS = 8'h0A;

    // ------------------------------------------------------------
    // Parameter limits
    // ------------------------------------------------------------
    localparam logic [7:0] AUTH_PLAIN_CRC = 8'hFF;
    localparam logic [15:0] RSV_FILL = 16'h0000;
    localparam logic [15:0] CERT_SIZE_MAX = 16'h00D8;
    localparam logic [7:0] FREQ_SEL_MAX = 8'h03;
    localparam logic [7:0] SUPPLY_SEL_MAX = 8'h01;
    localparam logic [31:0] DRV_LEN_MAX = 32'h0003_7000;
    localparam logic [31:0] DRV_LEN_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------
    // Frame geometry
    // ------------------------------------------------------------
    localparam int FRAME_MAX = 12;
    localparam logic [3:0] CERT_FRAME_LEN = 4'hB;
    localparam logic [3:0] FLASH_FRAME_LEN = 4'hC;
    localparam int RSP_BODY_MAX = 10;
    localparam int POS_RES = 0;
    localparam int POS_STS = 1;
    localparam int POS_DETAIL = 2;
    localparam int POS_LOC = 6;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 20;
    localparam int REPLY_WAIT_US = 1000;
    localparam int REPLY_WAIT_CYCLES = REPLY_WAIT_US * CLK_MHZ;

    typedef logic [FRAME_MAX-1:0][7:0] cchk_frame_t;
    typedef logic [RSP_BODY_MAX-1:0][7:0] cchk_body_t;

endpackage

// ==== src/cchk_rsp_if.sv ====
interface cchk_rsp_if;
    import cchk_pkg::*;
    logic valid;
    logic good;
    logic [7:0] len;
    cchk_body_t body;
    modport src (output valid, output good, output len, output body);
    modport dst (input valid, input good, input len, input body);
endinterface

// ==== src/cchk_reply_rx.sv ====
module cchk_reply_rx import cchk_pkg::*; (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] rxData,
    input wire logic rxValid,
    cchk_rsp_if.src rsp
);

    typedef enum {RX_HUNT, RX_LENH, RX_LENL, RX_BODY, RX_SUM, RX_END}
        cchk_rx_state_t;

    cchk_rx_state_t state_q, state_d;
    logic [7:0] len_q, len_d;
    logic [7:0] cnt_q, cnt_d;
    logic [7:0] sum_q, sum_d;
    logic bad_q, bad_d;
    logic sumOk_q, sumOk_d;
    logic valid_q, valid_d;
    logic good_q, good_d;
    cchk_body_t body_q, body_d;

    always_comb begin
        state_d = state_q;
        len_d = len_q;
        cnt_d = cnt_q;
        sum_d = sum_q;
        bad_d = bad_q;
        sumOk_d = sumOk_q;
        body_d = body_q;
        valid_d = 1'b0;
        good_d = good_q;
        if (rxValid) begin
            case (state_q)
                RX_HUNT: begin
                    // Skip line noise until a reply header appears
                    if (rxData == DATA_START_BYTE) begin
                        state_d = RX_LENH;
                        sum_d = 8'h00;
                        bad_d = 1'b0;
                    end
                end
                RX_LENH: begin
                    bad_d = (rxData != LEN_HIGH_BYTE);
                    sum_d = sum_q + rxData;
                    state_d = RX_LENL;
                end
                RX_LENL: begin
                    len_d = rxData;
                    sum_d = sum_q + rxData;
                    cnt_d = 8'h00;
                    // A length the body store cannot hold ends the frame
                    if (bad_q || rxData == 8'h00 || rxData > LEN_STATUS) begin
                        valid_d = 1'b1;
                        good_d = 1'b0;
                        state_d = RX_HUNT;
                    end else begin
                        state_d = RX_BODY;
                    end
                end
                RX_BODY: begin
                    body_d[cnt_q[3:0]] = rxData;
                    sum_d = sum_q + rxData;
                    cnt_d = cnt_q + 8'h01;
                    if (cnt_q == len_q - 8'h01) begin
                        state_d = RX_SUM;
                    end
                end
                RX_SUM: begin
                    // sum from length high up plus check byte is zero
                    sumOk_d = ((sum_q + rxData) == 8'h00);
                    state_d = RX_END;
                end
                RX_END: begin
                    valid_d = 1'b1;
                    good_d = (rxData == END_BYTE) && sumOk_q;
                    state_d = RX_HUNT;
                end
                default: state_d = RX_HUNT;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= RX_HUNT;
            len_q <= 8'h00;
            cnt_q <= 8'h00;
            sum_q <= 8'h00;
            bad_q <= 1'b0;
            sumOk_q <= 1'b0;
            valid_q <= 1'b0;
            good_q <= 1'b0;
            body_q <= '0;
        end else begin
            state_q <= state_d;
            len_q <= len_d;
            cnt_q <= cnt_d;
            sum_q <= sum_d;
            bad_q <= bad_d;
            sumOk_q <= sumOk_d;
            valid_q <= valid_d;
            good_q <= good_d;
            body_q <= body_d;
        end
    end

    assign rsp.valid = valid_q;
    assign rsp.good = good_q;
    assign rsp.len = len_q;
    assign rsp.body = body_q;

endmodule // cchk_reply_rx

// ==== tb/cchk_host_asserts.sv ====
module cchk_host_asserts import cchk_pkg::*; (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cmdStart,
    input wire logic cmdFlash,
    input wire logic loaderReady,
    input wire logic [7:0] authKind,
    input wire logic [15:0] certSize,
    input wire logic [31:0] driverLen,
    input wire logic busy,
    input wire logic cmdRefused,
    input wire logic cmdDone,
    input wire logic replyOk,
    input wire logic [7:0] replyCode,
    input wire logic [31:0] failLocation,
    input wire logic [7:0] txData,
    input wire logic txValid,
    input wire logic txReady
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic take;
    assign take = cmdStart && !busy;

    auth_refuse_a: assert property (
        take && !cmdFlash && authKind != AUTH_PLAIN_CRC |=> cmdRefused)
        else $error("bad auth kind taken");
    size_refuse_a: assert property (
        take && !cmdFlash && certSize > CERT_SIZE_MAX |=> cmdRefused)
        else $error("oversize certificate taken");
    loader_refuse_a: assert property (
        take && !cmdFlash && !loaderReady |=> cmdRefused)
        else $error("check taken without loader");
    drvlen_refuse_a: assert property (
        take && cmdFlash && (driverLen == DRV_LEN_ZERO
        || driverLen > DRV_LEN_MAX) |=> cmdRefused)
        else $error("bad driver length taken");
    frame_head_a: assert property (
        $rose(busy) |-> txValid && txData == HDR_START_BYTE)
        else $error("frame not opened by header");
    tx_hold_a: assert property (
        txValid && !txReady |=> txValid && $stable(txData))
        else $error("byte changed before taken");
    trust_loc_a: assert property (
        cmdDone && replyCode == RES_CERT_ERR
        |-> !replyOk && failLocation == 32'hFFFF_FFFF)
        else $error("error reply misreported");
    ok_code_a: assert property (
        cmdDone && replyOk |-> replyCode == CMD_CERT_CHECK
        || replyCode == CMD_FLASH_SET)
        else $error("good reply with odd code");
    refuse_quiet_a: assert property (
        cmdRefused |-> !busy && !txValid)
        else $error("refused command sends");
    done_pulse_a: assert property (
        cmdDone |-> !busy ##1 !cmdDone)
        else $error("done not a single pulse");
endmodule // cchk_host_asserts

bind cchk_host cchk_host_asserts cchk_host_asserts_inst (
    .clk(clk), .sys_rst(sys_rst), .cmdStart(cmdStart),
    .cmdFlash(cmdFlash), .loaderReady(loaderReady), .authKind(authKind),
    .certSize(certSize), .driverLen(driverLen), .busy(busy),
    .cmdRefused(cmdRefused), .cmdDone(cmdDone), .replyOk(replyOk),
    .replyCode(replyCode), .failLocation(failLocation),
    .txData(txData), .txValid(txValid), .txReady(txReady));

// ==== tb/cchk_dev_model.sv ====
module cchk_dev_model import cchk_pkg::*; #(
    parameter logic [7:0] ST_PKT = 8'hC1,
    parameter logic [7:0] ST_SUM = 8'hC2,
    parameter logic [7:0] ST_PRM = 8'hC3,
    parameter logic [7:0] ST_TRUST = 8'hC4,
    parameter logic [31:0] TRUST_STAT = 32'h0000_1234
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] txData,
    input wire logic txValid,
    output logic txReady,
    output logic [7:0] rxData,
    output logic rxValid,
    input wire logic crcBad,
    input wire logic slow,
    input wire logic mute,
    input wire logic corrupt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] fr[$];
    logic [7:0] rs[$];

    task automatic send(input logic [7:0] b[$]);
        logic [7:0] s;
        s = 8'h00;
        if (slow) rs.push_back(8'h3C);
        rs.push_back(DATA_START_BYTE);
        foreach (b[i]) begin
            rs.push_back(b[i]);
            s = s + b[i];
        end
        rs.push_back(corrupt ? 8'h01 - s : 8'h00 - s);
        rs.push_back(END_BYTE);
    endtask

    task automatic err(input logic [7:0] st, input logic [31:0] d);
        send({LEN_HIGH_BYTE, LEN_STATUS, fr[3] | 8'h80, st, d[31:24],
              d[23:16], d[15:8], d[7:0], 8'hFF, 8'hFF, 8'hFF, 8'hFF});
    endtask

    task automatic judge();
        logic [7:0] s;
        logic [31:0] dl;
        int n;
        n = fr.size();
        s = 8'h00;
        for (int i = 1; i < n - 1; i++) s = s + fr[i];
        dl = (n > 9) ? {fr[6], fr[7], fr[8], fr[9]} : 32'h0;
        // first fault in priority order wins
        if (fr[n-1] != END_BYTE) err(ST_PKT, '1);
        else if (s != 8'h00) err(ST_SUM, '1);
        else if (fr[1] != LEN_HIGH_BYTE || fr[2] != (fr[3] == CMD_CERT_CHECK
                 ? LEN_CERT_CMD : LEN_FLASH_CMD)) err(ST_PKT, '1);
        else if (fr[3] == CMD_CERT_CHECK && (fr[4] != AUTH_PLAIN_CRC
                 || {fr[7], fr[8]} > CERT_SIZE_MAX)) err(ST_PRM, '1);
        else if (fr[3] != CMD_CERT_CHECK && (fr[4] > FREQ_SEL_MAX
                 || fr[5] > SUPPLY_SEL_MAX || dl == DRV_LEN_ZERO
                 || dl > DRV_LEN_MAX)) err(ST_PRM, '1);
        else if (fr[3] == CMD_CERT_CHECK && crcBad) err(ST_TRUST, TRUST_STAT);
        else if (fr[3] == CMD_CERT_CHECK) send({LEN_HIGH_BYTE, LEN_CERT_OK,
                 fr[3], 8'hFF, 8'hFF, 8'hFF, 8'hFF});
        else send({LEN_HIGH_BYTE, LEN_STATUS, fr[3], 8'h00, 8'hFF, 8'hFF,
                   8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF});
    endtask

    always @(posedge clk) begin
        if (sys_rst) begin
            fr.delete();
            rs.delete();
            txReady <= 1'b0;
            rxValid <= 1'b0;
            rxData <= 8'h00;
        end else begin
            txReady <= slow ? !txReady : 1'b1;
            if (txValid && txReady) begin
                if (fr.size() > 0 || txData == HDR_START_BYTE) begin
                    fr.push_back(txData);
                end
                // frame is length plus five bytes
                if (fr.size() > 3 && fr.size() == int'(fr[2]) + 5) begin
                    if (!mute) judge();
                    fr.delete();
                end
            end
            if (rs.size() > 0) begin
                rxValid <= 1'b1;
                rxData <= rs.pop_front();
            end else begin
                // Idle line toggles so stale data never looks valid
                rxValid <= 1'b0;
                rxData <= ~rxData;
            end
        end
    end
endmodule // cchk_dev_model

// ==== tb/cchk_host_bench.sv ====
module cchk_host_bench import cchk_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WAIT = 50;
    localparam logic [7:0] ST_TRUST = 8'hC4;
    localparam logic [31:0] TRUST_STAT = 32'h0000_1234;
    logic clk = 1'b0, sys_rst = 1'b1, cmdStart = 1'b0, cmdFlash = 1'b0;
    logic loaderReady = 1'b1, crcBad = 1'b0, slow = 1'b0;
    logic mute = 1'b0, corrupt = 1'b0;
    logic [7:0] authKind = 8'h00, freqSel = 8'h00, supplySel = 8'h00;
    logic [15:0] certSize = 16'h0000;
    logic [31:0] driverLen = 32'h0;
    logic busy, cmdRefused, cmdDone, replyOk, linkErr, flashConfigured;
    logic txValid, txReady, rxValid, refused;
    logic [7:0] replyCode, statusCode, txData, rxData;
    logic [31:0] statusDetail, failLocation;
    logic [7:0] sent[$];
    logic [7:0] expq[$];
    int miscompares = 0;
    int checkCount = 0;

    always #25 clk = ~clk;

    cchk_host #(.REPLY_WAIT(WAIT)) cchk_host_inst (
        .clk(clk), .sys_rst(sys_rst), .cmdStart(cmdStart),
        .cmdFlash(cmdFlash), .loaderReady(loaderReady), .authKind(authKind),
        .certSize(certSize), .freqSel(freqSel), .supplySel(supplySel),
        .driverLen(driverLen), .busy(busy), .cmdRefused(cmdRefused),
        .cmdDone(cmdDone), .replyOk(replyOk), .linkErr(linkErr),
        .replyCode(replyCode), .statusCode(statusCode),
        .statusDetail(statusDetail), .failLocation(failLocation),
        .flashConfigured(flashConfigured), .txData(txData),
        .txValid(txValid), .txReady(txReady), .rxData(rxData),
        .rxValid(rxValid));

    cchk_dev_model #(.ST_TRUST(ST_TRUST), .TRUST_STAT(TRUST_STAT))
    cchk_dev_model_inst (
        .clk(clk), .sys_rst(sys_rst), .txData(txData), .txValid(txValid),
        .txReady(txReady), .rxData(rxData), .rxValid(rxValid),
        .crcBad(crcBad), .slow(slow), .mute(mute), .corrupt(corrupt));

    always @(posedge clk) begin
        if (txValid === 1'b1 && txReady === 1'b1) sent.push_back(txData);
    end

    task automatic conclude();
        $display("checks %0d miscompares %0d", checkCount, miscompares);
        if (miscompares == 0 && checkCount > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chkBit(input logic got, input logic exp);
        checkCount++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t flag %b not %b", $time, got, exp);
        end
    endtask

    task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t value %h not %h", $time, got, exp);
        end
    endtask

    task automatic issue(input logic f, input logic lr, input logic [7:0] a,
        input logic [15:0] s, input logic [7:0] q, input logic [7:0] v,
        input logic [31:0] l);
        int n;
        sent.delete();
        @(posedge clk);
        {cmdFlash, loaderReady, authKind, certSize} <= {f, lr, a, s};
        {freqSel, supplySel, driverLen} <= {q, v, l};
        cmdStart <= 1'b1;
        @(posedge clk);
        cmdStart <= 1'b0;
        n = 0;
        while (cmdDone !== 1'b1 && cmdRefused !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        refused = cmdRefused;
        if (n >= 400) begin
            miscompares++;
            conclude();
        end
    endtask

    // Expected frame: header, body, check byte, terminator
    task automatic chkFrame();
        logic [7:0] s;
        s = 8'h00;
        foreach (expq[i]) s = s + expq[i];
        expq = {HDR_START_BYTE, expq, 8'h00 - s, END_BYTE};
        chkWord(32'(sent.size()), 32'(expq.size()));
        foreach (expq[i]) begin
            if (i < sent.size()) chkWord({24'h0, sent[i]}, {24'h0, expq[i]});
        end
    endtask

    task automatic cert(input logic [15:0] s);
        expq = {LEN_HIGH_BYTE, LEN_CERT_CMD, CMD_CERT_CHECK, AUTH_PLAIN_CRC,
                8'h00, 8'h00, s[15:8], s[7:0]};
        issue(1'b0, 1'b1, AUTH_PLAIN_CRC, s, 8'h00, 8'h00, 32'h0);
    endtask

    task automatic refuse(input logic f, input logic lr, input logic [7:0] a,
        input logic [15:0] s, input logic [7:0] q, input logic [7:0] v,
        input logic [31:0] l);
        issue(f, lr, a, s, q, v, l);
        chkBit(refused, 1'b1);
        chkWord(32'(sent.size()), 32'h0);
    endtask

    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        slow <= 1'b1;
        cert(CERT_SIZE_MAX);
        chkFrame();
        chkBit(replyOk, 1'b1);
        chkWord({24'h0, replyCode}, 32'h27);
        slow <= 1'b0;
        crcBad <= 1'b1;
        cert(16'h0001);
        chkBit(replyOk, 1'b0);
        chkWord({24'h0, replyCode}, 32'hA7);
        chkWord({24'h0, statusCode}, {24'h0, ST_TRUST});
        chkWord(statusDetail, TRUST_STAT);
        chkWord(failLocation, 32'hFFFF_FFFF);
        chkBit(linkErr, 1'b0);
        crcBad <= 1'b0;
        refuse(1'b0, 1'b1, 8'hFE, 16'h1, 8'h0, 8'h0, 32'h1);
        refuse(1'b0, 1'b1, 8'hFF, 16'hD9, 8'h0, 8'h0, 32'h1);
        refuse(1'b0, 1'b0, 8'hFF, 16'h1, 8'h0, 8'h0, 32'h1);
        refuse(1'b1, 1'b1, 8'hFF, 16'h0, 8'h4, 8'h0, 32'h8);
        refuse(1'b1, 1'b1, 8'hFF, 16'h0, 8'h0, 8'h2, 32'h8);
        refuse(1'b1, 1'b1, 8'hFF, 16'h0, 8'h0, 8'h0, 32'h0);
        refuse(1'b1, 1'b1, 8'hFF, 16'h0, 8'h0, 8'h0, 32'h37001);
        for (int f = 0; f < 4; f++) begin
            logic [31:0] dl;
            dl = (f == 3) ? DRV_LEN_MAX : 32'h0000_0800;
            expq = {LEN_HIGH_BYTE, LEN_FLASH_CMD, CMD_FLASH_SET, 8'(f),
                    8'(f % 2), dl[31:24], dl[23:16], dl[15:8], dl[7:0]};
            issue(1'b1, 1'b1, 8'hFF, 16'h0, 8'(f), 8'(f % 2), dl);
            chkFrame();
            chkBit(flashConfigured, 1'b1);
            chkWord({24'h0, replyCode}, 32'h36);
        end
        // Silent device: host must give up after its reply wait
        mute <= 1'b1;
        issue(1'b1, 1'b1, 8'hFF, 16'h0, 8'h1, 8'h1, 32'h1);
        chkBit(linkErr, 1'b1);
        chkBit(flashConfigured, 1'b0);
        mute <= 1'b0;
        corrupt <= 1'b1;
        cert(16'h0010);
        chkBit(linkErr, 1'b1);
        chkBit(replyOk, 1'b0);
        corrupt <= 1'b0;
        cert(16'h0000);
        chkBit(replyOk, 1'b1);
        conclude();
    end
endmodule // cchk_host_bench
